// [rtl/hs_defs.svh]
`ifndef HS_DEFS_SVH
`define HS_DEFS_SVH

// Width of the synchroniser vector: external reset pin plus seven strap pins.
`define HS_SYNC_W 8

// Bit positions inside the synchroniser vector.
`define HS_BIT_EXT_RST 0
`define HS_BIT_MGMT_LO 1
`define HS_BIT_MGMT_HI 2
`define HS_BIT_EE_TYPE 3
`define HS_BIT_EE_SZ_LO 4
`define HS_BIT_EE_SZ_HI 5
`define HS_BIT_XMII 6
`define HS_BIT_ADDR_SEL 7

// Reset values.
`define HS_SYNC_RST 8'h00
`define HS_VALID_RST 1'h0
`define HS_UNMANAGED_RST 1'h1
`define HS_MODE_OTHER_RST 1'h0
`define HS_MGMT_RST 2'h0
`define HS_EE_TYPE_RST 1'h0
`define HS_EE_SIZE_RST 2'h0
`define HS_XMII_RST 1'h0
`define HS_ADDR_SEL_RST 1'h0

// Management address bases; the address select strap adds to each.
`define HS_VPHY_BASE 5'h00
`define HS_PHY1_BASE 5'h01
`define HS_PHY2_BASE 5'h02

`endif

// [rtl/hs_pkg.sv]
`default_nettype none
`include "hs_defs.svh"

package hs_pkg;

    typedef enum logic [1:0] {
        HS_MGMT_UNMANAGED,
        HS_MGMT_EXT_MDIO,
        HS_MGMT_I2C,
        HS_MGMT_SPI
    } hs_mgmt_mode_t;

    typedef enum logic {
        HS_EE_THREE_WIRE,
        HS_EE_I2C
    } hs_ee_proto_t;

    typedef enum logic {
        HS_XMII_MAC,
        HS_XMII_PHY
    } hs_xmii_role_t;

    typedef enum logic {
        HS_CAP_HOLD,
        HS_CAP_DONE
    } hs_cap_state_t;

    // Management address for one port from its base and the select strap.
    function automatic logic [4:0] hs_phy_addr(input logic [4:0] base, input logic sel);
        hs_phy_addr = base + {4'h0, sel};
    endfunction

endpackage

`default_nettype wire

// [rtl/hs_strap_latch.sv]
// How it works
// - Straps are captured only after power-on reset or the external reset pin.
// - Each strap has its own pin; no loader path can overwrite it.
// - Captured values drive logic directly or serve as register reset defaults.
// - Management mode code: 00 unmanaged, 01 extended MDIO, 10 I2C, 11 SPI.
// - EEPROM kind strap: 0 three-wire protocol, 1 I2C protocol.
// - Two-bit EEPROM capacity strap sets the size range for addressing.
// - Address select strap sets default addresses of both PHYs and virtual PHY.
// - Select 0 gives addresses 0,1,2; select 1 gives 1,2,3.
`timescale 1ns/10ps
`default_nettype none
`include "hs_defs.svh"

module hs_strap_latch import hs_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic external_reset_n_i,
    input wire logic other_reset_i,
    input wire logic [1:0] mgmt_mode_pin_i,
    input wire logic eeprom_type_pin_i,
    input wire logic [1:0] eeprom_size_pin_i,
    input wire logic xmii_mode_pin_i,
    input wire logic phy_addr_sel_pin_i,
    output logic straps_valid_o,
    output logic [1:0] mgmt_mode_o,
    output logic mode_unmanaged_o,
    output logic mode_ext_mdio_o,
    output logic mode_i2c_o,
    output logic mode_spi_o,
    output logic eeprom_i2c_o,
    output logic [1:0] eeprom_size_o,
    output logic xmii_phy_role_o,
    output logic phy_addr_sel_o,
    output logic [4:0] vphy_addr_o,
    output logic [4:0] phy1_addr_o,
    output logic [4:0] phy2_addr_o
);

    logic [`HS_SYNC_W-1:0] pins_raw;
    logic [`HS_SYNC_W-1:0] pins_s;
    logic ext_rst_n_s;
    logic [1:0] mgmt_s;
    logic ee_type_s;
    logic [1:0] ee_size_s;
    logic xmii_s;
    logic addr_sel_s;
    logic capture;
    hs_cap_state_t state_q;
    hs_mgmt_mode_t mode_dec;

    // All pins share one synchroniser so the straps and the reset pin arrive
    // with the same latency; a strap is never sampled a cycle ahead of reset.
    assign pins_raw[`HS_BIT_EXT_RST] = external_reset_n_i;
    assign pins_raw[`HS_BIT_MGMT_HI:`HS_BIT_MGMT_LO] = mgmt_mode_pin_i;
    assign pins_raw[`HS_BIT_EE_TYPE] = eeprom_type_pin_i;
    assign pins_raw[`HS_BIT_EE_SZ_HI:`HS_BIT_EE_SZ_LO] = eeprom_size_pin_i;
    assign pins_raw[`HS_BIT_XMII] = xmii_mode_pin_i;
    assign pins_raw[`HS_BIT_ADDR_SEL] = phy_addr_sel_pin_i;

    hs_sync2 u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    assign ext_rst_n_s = pins_s[`HS_BIT_EXT_RST];
    assign mgmt_s = pins_s[`HS_BIT_MGMT_HI:`HS_BIT_MGMT_LO];
    assign ee_type_s = pins_s[`HS_BIT_EE_TYPE];
    assign ee_size_s = pins_s[`HS_BIT_EE_SZ_HI:`HS_BIT_EE_SZ_LO];
    assign xmii_s = pins_s[`HS_BIT_XMII];
    assign addr_sel_s = pins_s[`HS_BIT_ADDR_SEL];

    // The capture happens on the first edge where the synchronised reset pin
    // reads released while a capture is pending. Power-on reset leaves the
    // synchronised pin low, so it also lands in HOLD. The other reset input
    // has no path into this logic on purpose.
    assign capture = (state_q == HS_CAP_HOLD) && ext_rst_n_s;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= HS_CAP_HOLD;
        end else begin
            case (state_q)
                HS_CAP_HOLD: begin
                    if (ext_rst_n_s) begin
                        state_q <= HS_CAP_DONE;
                    end
                end
                HS_CAP_DONE: begin
                    if (!ext_rst_n_s) begin
                        state_q <= HS_CAP_HOLD;
                    end
                end
                default: begin
                    state_q <= HS_CAP_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            straps_valid_o <= `HS_VALID_RST;
        end else begin
            straps_valid_o <= ext_rst_n_s && (capture || straps_valid_o);
        end
    end

    // Management mode, kept both as the raw default code and as decoded lines.
    always_comb begin
        case (mgmt_s)
            HS_MGMT_UNMANAGED: mode_dec = HS_MGMT_UNMANAGED;
            HS_MGMT_EXT_MDIO: mode_dec = HS_MGMT_EXT_MDIO;
            HS_MGMT_I2C: mode_dec = HS_MGMT_I2C;
            HS_MGMT_SPI: mode_dec = HS_MGMT_SPI;
            default: mode_dec = HS_MGMT_UNMANAGED;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mgmt_mode_o <= `HS_MGMT_RST;
            mode_unmanaged_o <= `HS_UNMANAGED_RST;
            mode_ext_mdio_o <= `HS_MODE_OTHER_RST;
            mode_i2c_o <= `HS_MODE_OTHER_RST;
            mode_spi_o <= `HS_MODE_OTHER_RST;
        end else if (capture) begin
            mgmt_mode_o <= mode_dec;
            mode_unmanaged_o <= (mode_dec == HS_MGMT_UNMANAGED);
            mode_ext_mdio_o <= (mode_dec == HS_MGMT_EXT_MDIO);
            mode_i2c_o <= (mode_dec == HS_MGMT_I2C);
            mode_spi_o <= (mode_dec == HS_MGMT_SPI);
        end
    end

    // Only the capture edge writes these; no loader input exists.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eeprom_i2c_o <= `HS_EE_TYPE_RST;
            eeprom_size_o <= `HS_EE_SIZE_RST;
        end else if (capture) begin
            eeprom_i2c_o <= (ee_type_s == HS_EE_I2C);
            eeprom_size_o <= ee_size_s;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xmii_phy_role_o <= `HS_XMII_RST;
        end else if (capture) begin
            xmii_phy_role_o <= (xmii_s == HS_XMII_PHY);
        end
    end

    // Addresses are register reset defaults for the management decoders.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phy_addr_sel_o <= `HS_ADDR_SEL_RST;
            vphy_addr_o <= `HS_VPHY_BASE;
            phy1_addr_o <= `HS_PHY1_BASE;
            phy2_addr_o <= `HS_PHY2_BASE;
        end else if (capture) begin
            phy_addr_sel_o <= addr_sel_s;
            vphy_addr_o <= hs_phy_addr(`HS_VPHY_BASE, addr_sel_s);
            phy1_addr_o <= hs_phy_addr(`HS_PHY1_BASE, addr_sel_s);
            phy2_addr_o <= hs_phy_addr(`HS_PHY2_BASE, addr_sel_s);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_capture_mode: assert property (
        capture |=> straps_valid_o && (mgmt_mode_o == $past(mgmt_s)))
        else $error("mode code not captured at reset release");

    a_no_capture_locked: assert property (
        (straps_valid_o && ext_rst_n_s) |=> $stable({mgmt_mode_o, eeprom_i2c_o,
            eeprom_size_o, xmii_phy_role_o, vphy_addr_o, phy1_addr_o, phy2_addr_o}))
        else $error("strap value changed outside a capture");

    a_other_reset_keeps: assert property (
        (other_reset_i && straps_valid_o && ext_rst_n_s) |=> straps_valid_o
            && $stable({mgmt_mode_o, eeprom_i2c_o, eeprom_size_o, xmii_phy_role_o,
            phy_addr_sel_o}))
        else $error("other reset disturbed captured straps");

    a_invalid_in_reset: assert property (
        !ext_rst_n_s |=> !straps_valid_o ##1 (!straps_valid_o || $past(ext_rst_n_s)))
        else $error("valid flag high during external reset");

    a_mode_decode: assert property (
        straps_valid_o |-> ($countones({mode_unmanaged_o, mode_ext_mdio_o,
            mode_i2c_o, mode_spi_o}) == 1) && (mode_spi_o == (mgmt_mode_o == HS_MGMT_SPI))
            && (mode_i2c_o == (mgmt_mode_o == HS_MGMT_I2C))
            && (mode_ext_mdio_o == (mgmt_mode_o == HS_MGMT_EXT_MDIO)))
        else $error("decoded management mode disagrees with code");

    a_eeprom_proto: assert property (
        capture |=> eeprom_i2c_o == $past(ee_type_s))
        else $error("EEPROM protocol not taken from strap");

    a_eeprom_size: assert property (
        capture ##1 straps_valid_o |-> eeprom_size_o == $past(ee_size_s))
        else $error("EEPROM size range not taken from strap");

    a_xmii_role: assert property (
        capture |=> xmii_phy_role_o == $past(xmii_s))
        else $error("external port role not taken from strap");

    a_addr_sel_zero: assert property (
        (straps_valid_o && !phy_addr_sel_o) |-> (vphy_addr_o == `HS_VPHY_BASE)
            && (phy1_addr_o == `HS_PHY1_BASE) && (phy2_addr_o == `HS_PHY2_BASE))
        else $error("addresses wrong for select zero");

    a_addr_sel_one: assert property (
        (straps_valid_o && phy_addr_sel_o) |-> (vphy_addr_o == `HS_PHY1_BASE)
            && (phy1_addr_o == `HS_PHY2_BASE) && (phy2_addr_o == `HS_PHY2_BASE + 5'h01))
        else $error("addresses wrong for select one");

    c_first_capture: cover property (capture ##1 straps_valid_o);
    c_recapture: cover property (straps_valid_o ##1 !straps_valid_o [*2] ##[1:20] capture);
    c_spi_mode: cover property (straps_valid_o && mode_spi_o);
    c_addr_sel_one: cover property (straps_valid_o && phy_addr_sel_o && xmii_phy_role_o);

endmodule // hs_strap_latch

`default_nettype wire

// [rtl/hs_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
`include "hs_defs.svh"

module hs_sync2 import hs_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [`HS_SYNC_W-1:0] d_i,
    output logic [`HS_SYNC_W-1:0] q_o
);

    logic [`HS_SYNC_W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= `HS_SYNC_RST;
            q_o <= `HS_SYNC_RST;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule // hs_sync2

`default_nettype wire

// [verification/hs_strap_board.sv]
`timescale 1ns/10ps
`default_nettype none

// Board-level strap resistors: each pin is tied to a fixed level chosen by the bench.
// The levels only move while the device sits in reset or is known to ignore them.
module hs_strap_board import hs_pkg::*; (
    input wire logic [6:0] level_i,
    output logic [1:0] mgmt_mode_pin_o,
    output logic eeprom_type_pin_o,
    output logic [1:0] eeprom_size_pin_o,
    output logic xmii_mode_pin_o,
    output logic phy_addr_sel_pin_o
);
    // Every pin is a pure tie, so it is steady for as long as the chosen level is.
    assign mgmt_mode_pin_o = level_i[1:0];
    assign eeprom_type_pin_o = level_i[2];
    assign eeprom_size_pin_o = level_i[4:3];
    assign xmii_mode_pin_o = level_i[5];
    assign phy_addr_sel_pin_o = level_i[6];
endmodule // hs_strap_board

`default_nettype wire

// [verification/hs_strap_latch_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module hs_strap_latch_tb import hs_pkg::*;;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic ext_rst_n = 1'h1;
    logic other_rst = 1'h0;
    logic [6:0] straps = 7'h00;
    logic [1:0] mgmt_pin, size_pin, mgmt, size;
    logic ee_pin, role_pin, sel_pin, valid, unm, mdio, i2c, spi, ee, role, sel;
    logic [4:0] vphy, phy1, phy2;
    logic [6:0] w;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    hs_strap_board u_hs_strap_board (.level_i(straps), .mgmt_mode_pin_o(mgmt_pin),
        .eeprom_type_pin_o(ee_pin), .eeprom_size_pin_o(size_pin),
        .xmii_mode_pin_o(role_pin), .phy_addr_sel_pin_o(sel_pin));

    hs_strap_latch u_hs_strap_latch (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .external_reset_n_i(ext_rst_n), .other_reset_i(other_rst),
        .mgmt_mode_pin_i(mgmt_pin), .eeprom_type_pin_i(ee_pin), .eeprom_size_pin_i(size_pin),
        .xmii_mode_pin_i(role_pin), .phy_addr_sel_pin_i(sel_pin), .straps_valid_o(valid),
        .mgmt_mode_o(mgmt), .mode_unmanaged_o(unm), .mode_ext_mdio_o(mdio), .mode_i2c_o(i2c),
        .mode_spi_o(spi), .eeprom_i2c_o(ee), .eeprom_size_o(size), .xmii_phy_role_o(role),
        .phy_addr_sel_o(sel), .vphy_addr_o(vphy), .phy1_addr_o(phy1), .phy2_addr_o(phy2));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The latch answers within a few edges; twenty is a generous bound.
    task automatic wait_valid(input logic lvl);
        int n;
        n = 0;
        while (valid !== lvl && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0, valid}, {15'h0, lvl});
    endtask

    // Word layout: sel, role, size[1:0], eeprom kind, mode[1:0].
    task automatic check_outs(input logic [6:0] x);
        logic [4:0] base;
        base = {4'h0, x[6]};
        check({14'h0, mgmt}, {14'h0, x[1:0]});
        check({12'h0, spi, i2c, mdio, unm}, {12'h0, 4'h1 << x[1:0]});
        check({15'h0, ee}, {15'h0, x[2]});
        check({14'h0, size}, {14'h0, x[4:3]});
        check({15'h0, role}, {15'h0, x[5]});
        check({15'h0, sel}, {15'h0, x[6]});
        check({1'h0, vphy, phy1, phy2}, {1'h0, base, base + 5'h01, base + 5'h02});
    endtask

    task automatic power_on(input logic [6:0] x);
        @(negedge core_clk);
        rst_n = 1'h0;
        straps = x;
        repeat (3) @(negedge core_clk);
        rst_n = 1'h1;
        wait_valid(1'h1);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (12) @(negedge core_clk);
        check({15'h0, valid}, 16'h0000);
        check_outs(7'h00);
        rst_n = 1'h1;
        wait_valid(1'h1);
        check_outs(7'h00);
        for (int i = 0; i < 4; i++) begin
            w = {i[0] ^ i[1], i[1], 2'(3 - i), i[0], i[1:0]};
            power_on(w);
            check_outs(w);
        end
        // Pins move and a foreign reset fires; the captured set must not follow.
        straps = 7'h5c;
        other_rst = 1'h1;
        repeat (4) @(negedge core_clk);
        other_rst = 1'h0;
        repeat (6) @(negedge core_clk);
        check_outs(w);
        ext_rst_n = 1'h0;
        wait_valid(1'h0);
        check_outs(w);
        ext_rst_n = 1'h1;
        wait_valid(1'h1);
        check_outs(7'h5c);
        finish_test();
    end
endmodule // hs_strap_latch_tb

`default_nettype wire
